// ===== maint_monitor_pkg.sv
// shared constants of the maintenance timer and current pulse monitor
package maint_monitor_pkg;

  // clocking and time base
  localparam int unsigned CLK_HZ          = 50_000_000;
  localparam int unsigned TICK_MS         = 100;
  localparam int unsigned TICK_CYCLES_DEF = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned HOUR_MS         = 3_600_000;
  localparam int unsigned TENTHS_HOUR_DEF = HOUR_MS / TICK_MS;
  localparam int unsigned HOURS_PER_STEP  = 100;

  // energization count
  localparam logic [13:0] COUNT_MAX       = 14'h270e;
  localparam logic [13:0] THRESH_OFF      = 14'h270f;
  localparam logic [6:0]  SUB_LAST        = 7'(HOURS_PER_STEP - 1);

  // pulse sequence times in ms, converted to ticks
  localparam int unsigned CYCLE_MS        = 20000;
  localparam int unsigned START_MS        = 1000;
  localparam int unsigned INVALID_HI_MS   = 3500;
  localparam int unsigned CUR_MIN_MS      = 500;
  localparam int unsigned CUR_MAX_MS      = 9000;
  localparam int unsigned CUR_FULL_MS     = 5000;
  localparam int unsigned MAINT_MIN_MS    = 2000;
  localparam int unsigned MAINT_MAX_MS    = 9000;
  localparam int unsigned MASK_MAX_MS     = 20000;
  localparam int unsigned AVG_MIN_MS      = 100;
  localparam int unsigned AVG_MAX_MS      = 1000;
  localparam logic [7:0]  CYCLE_T         = 8'(CYCLE_MS / TICK_MS);
  localparam logic [7:0]  START_T         = 8'(START_MS / TICK_MS);
  localparam logic [7:0]  INVALID_HI_T    = 8'(INVALID_HI_MS / TICK_MS);
  localparam logic [7:0]  CUR_MIN_T       = 8'(CUR_MIN_MS / TICK_MS);
  localparam logic [7:0]  CUR_MAX_T       = 8'(CUR_MAX_MS / TICK_MS);
  localparam logic [7:0]  CUR_FULL_T      = 8'(CUR_FULL_MS / TICK_MS);
  localparam logic [7:0]  MAINT_MIN_T     = 8'(MAINT_MIN_MS / TICK_MS);
  localparam logic [7:0]  MAINT_MAX_T     = 8'(MAINT_MAX_MS / TICK_MS);
  localparam logic [7:0]  MASK_MAX_T      = 8'(MASK_MAX_MS / TICK_MS);
  localparam logic [3:0]  AVG_MIN_T       = 4'(AVG_MIN_MS / TICK_MS);
  localparam logic [3:0]  AVG_MAX_T       = 4'(AVG_MAX_MS / TICK_MS);

  // maintenance pulse scaling in hours and percent clamps
  localparam int unsigned MAINT_LO_HOURS  = 16000;
  localparam int unsigned MAINT_HI_HOURS  = 72000;
  localparam logic [13:0] MAINT_LO_CNT    = 14'(MAINT_LO_HOURS / HOURS_PER_STEP);
  localparam logic [13:0] MAINT_HI_CNT    = 14'(MAINT_HI_HOURS / HOURS_PER_STEP);
  localparam logic [7:0]  CUR_LO_PCT      = 8'h0a;
  localparam logic [7:0]  CUR_HI_PCT      = 8'hb4;
  localparam logic [8:0]  REF_MAX         = 9'h1f4;
  localparam logic [8:0]  RATED_DEF       = 9'h005;

  // output terminal function codes
  localparam logic [7:0]  FUNC_NONE       = 8'h00;
  localparam logic [7:0]  FUNC_PULSE_POS  = 8'h5d;
  localparam logic [7:0]  FUNC_ALARM_POS  = 8'h5f;
  localparam logic [7:0]  FUNC_PULSE_NEG  = 8'hc1;
  localparam logic [7:0]  FUNC_ALARM_NEG  = 8'hc3;
  localparam int unsigned TERM_N          = 3;
  localparam int unsigned TERM_RELAY      = 2;

  // register offsets
  localparam logic [7:0]  OFF_HOURS       = 8'h00;
  localparam logic [7:0]  OFF_THRESH      = 8'h04;
  localparam logic [7:0]  OFF_WINDOW      = 8'h08;
  localparam logic [7:0]  OFF_MASK        = 8'h0c;
  localparam logic [7:0]  OFF_REF         = 8'h10;
  localparam logic [7:0]  OFF_TERM_A      = 8'h14;
  localparam logic [7:0]  OFF_TERM_B      = 8'h18;
  localparam logic [7:0]  OFF_RELAY       = 8'h1c;
  localparam logic [7:0]  OFF_PROTECT     = 8'h20;
  localparam logic [7:0]  OFF_STATUS      = 8'h24;
  localparam logic [1:0]  PROTECT_LOCK    = 2'h1;
  localparam logic [1:0]  PROTECT_MAX     = 2'h2;

  typedef enum logic [7:0] {
    ST_IDLE    = 8'h01,
    ST_MASK    = 8'h02,
    ST_START   = 8'h04,
    ST_CURLOW  = 8'h08,
    ST_MAINTHI = 8'h10,
    ST_ENDLOW  = 8'h20,
    ST_BLANK   = 8'h40,
    ST_INVHI   = 8'h80
  } seq_state_e;

endpackage : maint_monitor_pkg

// ===== div_if.sv
// handshake between the sequencer and the serial divider
`timescale 1ns/100ps
`default_nettype none
interface div_if #(parameter int unsigned W = 24);
  logic         start;
  logic [W-1:0] numer;
  logic [W-1:0] denom;
  logic         done;
  logic [W-1:0] quot;
  modport master (output start, numer, denom, input done, quot);
  modport slave  (input start, numer, denom, output done, quot);
endinterface : div_if
`default_nettype wire

// ===== tick_divider.sv
// one-cycle enable pulse every CYCLES clocks
`timescale 1ns/100ps
`default_nettype none
module tick_divider #(
  parameter int unsigned CYCLES = 5000000
) (
  input  wire logic sys_clk,
  input  wire logic resetn,
  output logic      tick
);
  localparam int unsigned CW = $clog2(CYCLES + 1);

  logic [CW-1:0] cnt;

  if (CYCLES < 1)
  begin : g_bad
    $error("tick_divider needs CYCLES of at least one");
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cnt  <= '0;
      tick <= 1'b0;
    end
    else if (cnt == CW'(CYCLES - 1))
    begin
      cnt  <= '0;
      tick <= 1'b1;
    end
    else
    begin
      cnt  <= cnt + 1'b1;
      tick <= 1'b0;
    end
  end
endmodule : tick_divider
`default_nettype wire

// ===== serial_divider.sv
// restoring divider, one quotient bit per clock
`timescale 1ns/100ps
`default_nettype none
module serial_divider #(
  parameter int unsigned W = 24
) (
  input  wire logic sys_clk,
  input  wire logic resetn,
  div_if.slave      div
);
  localparam int unsigned CNT_W = $clog2(W + 1);

  logic [W-1:0]     rem;
  logic [W-1:0]     quo;
  logic [W-1:0]     den;
  logic [CNT_W-1:0] left;
  logic             busy;
  logic [W+1:0]     trial;

  if (W < 2)
  begin : g_bad
    $error("serial_divider needs W of at least two");
  end

  // borrow in the top bit means the divisor did not fit
  assign trial    = {1'b0, rem, quo[W-1]} - {2'b00, den};
  assign div.quot = quo;

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rem      <= '0;
      quo      <= '0;
      den      <= '0;
      left     <= '0;
      busy     <= 1'b0;
      div.done <= 1'b0;
    end
    else
    begin
      div.done <= 1'b0;
      if (div.start)
      begin
        rem  <= '0;
        quo  <= div.numer;
        den  <= div.denom;
        left <= CNT_W'(W);
        busy <= 1'b1;
      end
      else if (busy)
      begin
        if (!trial[W+1])
        begin
          rem <= trial[W-1:0];
          quo <= {quo[W-2:0], 1'b1};
        end
        else
        begin
          rem <= {rem[W-2:0], quo[W-1]};
          quo <= {quo[W-2:0], 1'b0};
        end
        left <= left - 1'b1;
        if (left == CNT_W'(1))
        begin
          busy     <= 1'b0;
          div.done <= 1'b1;
        end
      end
    end
  end
endmodule : serial_divider
`default_nettype wire

// ===== maint_current_monitor.sv
// maintenance timer and current average pulse monitor with apb registers
//
// Chosen here: the register addresses and the APB register port.
`timescale 1ns/100ps
`default_nettype none
module maint_current_monitor
  import maint_monitor_pkg::*;
#(
  parameter int unsigned TICK_CYCLES   = TICK_CYCLES_DEF,
  parameter int unsigned TENTHS_HOUR   = TENTHS_HOUR_DEF,
  parameter int unsigned CUR_W         = 10,
  parameter logic [8:0]  RATED_CURRENT = RATED_DEF
) (
  input  wire logic             sys_clk,
  input  wire logic             resetn,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [7:0]       paddr,
  input  wire logic [31:0]      pwdata,
  output logic [31:0]           prdata,
  output logic                  pready,
  output logic                  pslverr,
  input  wire logic             driveRunning,
  input  wire logic             accelDecel,
  input  wire logic             restartActive,
  input  wire logic             restartSelected,
  input  wire logic [CUR_W-1:0] outputCurrent,
  output logic                  maintenanceAlarmOut,
  output logic                  maintenanceDueIndication,
  output logic                  currentAvgPulseOut,
  output logic [TERM_N-1:0]     terminalOut,
  output logic                  nvSaveStrobe,
  output logic [13:0]           nvSaveCount
);
  localparam int unsigned DIV_W = 24;
  localparam int unsigned SUM_W = CUR_W + 4;

  if (CUR_W < 1 || CUR_W > 16 || TENTHS_HOUR < 1 || TENTHS_HOUR > 65535
      || TICK_CYCLES <= 2 * DIV_W)
  begin : g_bad
    $error("maint_current_monitor parameters out of range");
  end

  logic              tick;
  logic [15:0]       tenthCnt;
  logic [6:0]        subHundred;
  logic [13:0]       energizationHoursCount;
  logic [13:0]       maintenanceAlarmThreshold;
  logic [3:0]        currentAvgWindow;
  logic [7:0]        settleMaskTime;
  logic [8:0]        avgReferenceCurrent;
  logic [7:0]        termFunc [TERM_N];
  logic [1:0]        paramWriteProtectSel;
  logic              alarm;
  seq_state_e        state;
  seq_state_e        next_afterCycle;
  logic [7:0]        cycTenths;
  logic [7:0]        phaseTenths;
  logic [SUM_W-1:0]  sampleSum;
  logic [3:0]        sampleCount;
  logic [7:0]        lowTenths;
  logic [7:0]        maintTenths;
  logic [15:0]       maintSpan;
  logic              accelSeen;
  logic              prevConst;
  logic              constSpeed;
  logic              constEntry;
  logic              restartHit;
  logic              cycleEnd;
  logic              divGo;
  logic [DIV_W-1:0]  denomFull;
  logic [DIV_W-1:0]  sumPct;
  logic              mapped;
  logic              wrEn;
  logic              locked;
  logic              hoursClear;
  logic [31:0]       readMux;

  div_if #(.W(DIV_W)) divBus ();

  tick_divider #(.CYCLES(TICK_CYCLES)) u_tick (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .tick    (tick)
  );

  serial_divider #(.W(DIV_W)) u_div (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .div     (divBus)
  );

  // apb slave, zero wait states
  assign pready  = 1'b1;
  assign wrEn    = psel & penable & pwrite & mapped;
  assign pslverr = psel & penable & ~mapped;
  assign locked  = (paramWriteProtectSel == PROTECT_LOCK);
  assign hoursClear = wrEn & ~locked & (paddr == OFF_HOURS)
                      & (pwdata == 32'h0000_0000);

  always_comb
  begin
    mapped  = 1'b1;
    readMux = 32'h0000_0000;
    case (paddr)
      OFF_HOURS:   readMux[13:0] = energizationHoursCount;
      OFF_THRESH:  readMux[13:0] = maintenanceAlarmThreshold;
      OFF_WINDOW:  readMux[3:0]  = currentAvgWindow;
      OFF_MASK:    readMux[7:0]  = settleMaskTime;
      OFF_REF:     readMux[8:0]  = avgReferenceCurrent;
      OFF_TERM_A:  readMux[7:0]  = termFunc[0];
      OFF_TERM_B:  readMux[7:0]  = termFunc[1];
      OFF_RELAY:   readMux[7:0]  = termFunc[TERM_RELAY];
      OFF_PROTECT: readMux[1:0]  = paramWriteProtectSel;
      OFF_STATUS:  readMux[23:0] = {cycTenths, state, 5'h00,
                                    currentAvgPulseOut,
                                    maintenanceDueIndication, alarm};
      default:     mapped = 1'b0;
    endcase
  end

  // read data captured in the setup phase so it stands during access
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      prdata <= 32'h0000_0000;
    else if (psel & ~penable & ~pwrite)
      prdata <= readMux;
  end

  // configuration writes; out-of-range values are ignored
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      maintenanceAlarmThreshold <= THRESH_OFF;
      currentAvgWindow          <= AVG_MAX_T;
      settleMaskTime            <= 8'h00;
      avgReferenceCurrent       <= RATED_CURRENT;
      paramWriteProtectSel      <= 2'h0;
      for (int i = 0; i < TERM_N; i++)
        termFunc[i] <= FUNC_NONE;
    end
    else if (wrEn)
    begin
      case (paddr)
        OFF_THRESH:
          if (!locked && pwdata <= 32'(THRESH_OFF))
            maintenanceAlarmThreshold <= pwdata[13:0];
        // the next three ignore the protect lock and the run state
        OFF_WINDOW:
          if (pwdata >= 32'(AVG_MIN_T) && pwdata <= 32'(AVG_MAX_T))
            currentAvgWindow <= pwdata[3:0];
        OFF_MASK:
          if (pwdata <= 32'(MASK_MAX_T))
            settleMaskTime <= pwdata[7:0];
        OFF_REF:
          if (pwdata <= 32'(REF_MAX))
            avgReferenceCurrent <= pwdata[8:0];
        OFF_TERM_A:
          if (!locked && pwdata < 32'h100)
            termFunc[0] <= pwdata[7:0];
        OFF_TERM_B:
          if (!locked && pwdata < 32'h100)
            termFunc[1] <= pwdata[7:0];
        OFF_RELAY:
          if (!locked && pwdata < 32'h100 && pwdata[7:0] != FUNC_PULSE_POS
              && pwdata[7:0] != FUNC_PULSE_NEG)
            termFunc[TERM_RELAY] <= pwdata[7:0];
        OFF_PROTECT:
          if (pwdata <= 32'(PROTECT_MAX))
            paramWriteProtectSel <= pwdata[1:0];
        default:
          ;
      endcase
    end
  end

  // powered-on time; the partial 100-hour step is lost at power off
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      tenthCnt               <= 16'h0000;
      subHundred             <= 7'h00;
      energizationHoursCount <= 14'h0000;
      nvSaveStrobe           <= 1'b0;
    end
    else
    begin
      nvSaveStrobe <= 1'b0;
      if (hoursClear)
      begin
        tenthCnt               <= 16'h0000;
        subHundred             <= 7'h00;
        energizationHoursCount <= 14'h0000;
      end
      else if (tick)
      begin
        if (tenthCnt == 16'(TENTHS_HOUR - 1))
        begin
          tenthCnt     <= 16'h0000;
          nvSaveStrobe <= 1'b1;
          if (subHundred == SUB_LAST)
          begin
            subHundred <= 7'h00;
            if (energizationHoursCount != COUNT_MAX)
              energizationHoursCount <= energizationHoursCount + 1'b1;
          end
          else
            subHundred <= subHundred + 1'b1;
        end
        else
          tenthCnt <= tenthCnt + 1'b1;
      end
    end
  end

  assign nvSaveCount = energizationHoursCount;
  assign alarm = (maintenanceAlarmThreshold != THRESH_OFF)
                 && (energizationHoursCount >= maintenanceAlarmThreshold);

  // maintenance pulse length in ticks
  assign maintSpan = 16'(energizationHoursCount - MAINT_LO_CNT)
                     * 16'(MAINT_MAX_T - MAINT_MIN_T)
                     / 16'(MAINT_HI_CNT - MAINT_LO_CNT);
  always_comb
  begin
    if (energizationHoursCount <= MAINT_LO_CNT)
      maintTenths = MAINT_MIN_T;
    else if (energizationHoursCount >= MAINT_HI_CNT)
      maintTenths = MAINT_MAX_T;
    else
      maintTenths = MAINT_MIN_T + maintSpan[7:0];
  end

  // average over reference: low ticks = sum * 50 / (ref * samples)
  assign denomFull     = DIV_W'(avgReferenceCurrent) * DIV_W'(sampleCount);
  assign sumPct        = DIV_W'(sampleSum) * DIV_W'(8'h64);
  assign divBus.start  = divGo;
  assign divBus.numer  = DIV_W'(sampleSum) * DIV_W'(CUR_FULL_T);
  assign divBus.denom  = denomFull;

  assign constSpeed = driveRunning & ~accelDecel;
  assign constEntry = constSpeed & ~prevConst;
  assign restartHit = restartActive & restartSelected;
  assign cycleEnd   = tick && (cycTenths == CYCLE_T - 8'h01);

  // where a finished cycle goes next
  always_comb
  begin
    if (outputCurrent == '0 || !driveRunning)
      next_afterCycle = ST_IDLE;
    else if (accelDecel || restartHit)
      next_afterCycle = ST_BLANK;
    else if (accelSeen)
      next_afterCycle = ST_MASK;
    else
      next_afterCycle = ST_START;
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      prevConst <= 1'b0;
    else
      prevConst <= constSpeed;
  end

  // pulse sequencer
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state       <= ST_IDLE;
      cycTenths   <= 8'h00;
      phaseTenths <= 8'h00;
      sampleSum   <= '0;
      sampleCount <= 4'h0;
      lowTenths   <= CUR_MIN_T;
      accelSeen   <= 1'b0;
      divGo       <= 1'b0;
    end
    else
    begin
      divGo <= 1'b0;
      if (accelDecel)
        accelSeen <= 1'b1;
      if (tick && state != ST_IDLE && state != ST_MASK)
        cycTenths <= cycTenths + 1'b1;
      if (divBus.done)
      begin
        if (denomFull == '0 || sumPct > denomFull * DIV_W'(CUR_HI_PCT))
          lowTenths <= CUR_MAX_T;
        else if (sumPct < denomFull * DIV_W'(CUR_LO_PCT))
          lowTenths <= CUR_MIN_T;
        else
          lowTenths <= divBus.quot[7:0];
      end
      case (state)
        ST_IDLE:
          if (constEntry)
          begin
            state       <= ST_MASK;
            phaseTenths <= 8'h00;
          end
        ST_MASK:
          if (!constSpeed)
            state <= ST_IDLE;
          else if (phaseTenths >= settleMaskTime)
          begin
            state       <= restartHit ? ST_BLANK : ST_START;
            cycTenths   <= 8'h00;
            phaseTenths <= 8'h00;
            sampleSum   <= '0;
            sampleCount <= 4'h0;
            accelSeen   <= 1'b0;
          end
          else if (tick)
            phaseTenths <= phaseTenths + 1'b1;
        ST_START:
          if (accelDecel)
            state <= ST_INVHI;
          else if (tick)
          begin
            if (phaseTenths < 8'(currentAvgWindow))
            begin
              sampleSum   <= sampleSum + SUM_W'(outputCurrent);
              sampleCount <= sampleCount + 1'b1;
            end
            if (phaseTenths == START_T - 8'h01)
            begin
              state       <= ST_CURLOW;
              phaseTenths <= 8'h00;
              divGo       <= 1'b1;
            end
            else
              phaseTenths <= phaseTenths + 1'b1;
          end
        // from here on the cycle runs to its end whatever the speed does
        ST_CURLOW:
          if (tick)
          begin
            if (phaseTenths == lowTenths - 8'h01)
            begin
              state       <= ST_MAINTHI;
              phaseTenths <= 8'h00;
            end
            else
              phaseTenths <= phaseTenths + 1'b1;
          end
        ST_MAINTHI:
          if (tick)
          begin
            if (phaseTenths == maintTenths - 8'h01)
              state <= ST_ENDLOW;
            else
              phaseTenths <= phaseTenths + 1'b1;
          end
        ST_INVHI:
          if (tick && cycTenths == INVALID_HI_T - 8'h01)
            state <= ST_ENDLOW;
        ST_ENDLOW, ST_BLANK:
          if (cycleEnd)
          begin
            state       <= next_afterCycle;
            cycTenths   <= 8'h00;
            phaseTenths <= 8'h00;
            sampleSum   <= '0;
            sampleCount <= 4'h0;
            accelSeen   <= 1'b0;
          end
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  // registered outputs, one clock behind the state and the alarm
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      currentAvgPulseOut       <= 1'b0;
      maintenanceAlarmOut      <= 1'b0;
      maintenanceDueIndication <= 1'b0;
    end
    else
    begin
      currentAvgPulseOut <= (state == ST_START) || (state == ST_MAINTHI)
                            || (state == ST_INVHI);
      maintenanceAlarmOut      <= alarm;
      maintenanceDueIndication <= alarm;
    end
  end

  // terminal routing with polarity select
  for (genvar t = 0; t < TERM_N; t++)
  begin : g_term
    always_ff @(posedge sys_clk or negedge resetn)
    begin
      if (!resetn)
        terminalOut[t] <= 1'b0;
      else
      begin
        case (termFunc[t])
          FUNC_ALARM_POS: terminalOut[t] <= maintenanceAlarmOut;
          FUNC_ALARM_NEG: terminalOut[t] <= ~maintenanceAlarmOut;
          FUNC_PULSE_POS: terminalOut[t] <= currentAvgPulseOut;
          FUNC_PULSE_NEG: terminalOut[t] <= ~currentAvgPulseOut;
          default:        terminalOut[t] <= 1'b0;
        endcase
      end
    end
  end

endmodule : maint_current_monitor
`default_nettype wire

// ===== maint_current_monitor_props.sv
// port-level checks of the maintenance timer and pulse monitor
`timescale 1ns/100ps
`default_nettype none
module maint_current_monitor_props
  import maint_monitor_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = 100,
  parameter int unsigned TENTHS_HOUR = 3
) (
  input wire logic        sys_clk,
  input wire logic        resetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        maintenanceAlarmOut,
  input wire logic        maintenanceDueIndication,
  input wire logic        nvSaveStrobe,
  input wire logic [13:0] nvSaveCount
);
  localparam int HR = TICK_CYCLES * TENTHS_HOUR;
  int   gap;
  logic seen;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // the first gap after reset or an hours clear is not whole, so judge only whole gaps
  always_ff @(posedge sys_clk or negedge resetn)
    if (!resetn) gap <= 0;
    else gap <= nvSaveStrobe ? 0 : gap + 1;
  always_ff @(posedge sys_clk or negedge resetn)
    if (!resetn) seen <= 1'b0;
    else seen <= (seen | nvSaveStrobe) & ~(psel && penable && pwrite
      && paddr == OFF_HOURS && pwdata == 32'h0);
  property p_ready; pready; endproperty
  a_ready: assert property (p_ready) else $error("pready low");
  property p_err; pslverr |-> psel && penable; endproperty
  a_err: assert property (p_err) else $error("pslverr out of access");
  property p_errdat; pslverr |-> prdata == 32'h0; endproperty
  a_errdat: assert property (p_errdat) else $error("prdata on error");
  property p_hold; psel && penable && !pwrite |=> $stable(prdata);
  endproperty
  a_hold: assert property (p_hold) else $error("prdata not held");
  property p_ind; maintenanceAlarmOut == maintenanceDueIndication;
  endproperty
  a_ind: assert property (p_ind) else $error("alarm and indication");
  property p_sat; nvSaveCount <= COUNT_MAX; endproperty
  a_sat: assert property (p_sat) else $error("count above max");
  property p_step; $changed(nvSaveCount) |-> nvSaveCount == 14'h0 ||
    nvSaveCount == $past(nvSaveCount) + 14'h1; endproperty
  a_step: assert property (p_step) else $error("count jump");
  property p_hour; seen && nvSaveStrobe |-> gap == HR - 1; endproperty
  a_hour: assert property (p_hour) else $error("hour gap");
endmodule : maint_current_monitor_props
`default_nettype wire

// ===== plc_input_model.sv
// controller input: measures each level of the pulse train in clocks
`timescale 1ns/100ps
`default_nettype none
module plc_input_model (
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  input  wire logic        pulseIn,
  output logic             segEvt,
  output logic             segLvl,
  output logic [15:0]      segLen
);
  logic [15:0] run;
  logic        cur;
  // an input card sees only levels, so it reports each finished level and its width
  always_ff @(posedge sys_clk or negedge resetn)
    if (!resetn)
    begin
      run <= 16'h1;
      cur <= 1'b0;
      segEvt <= 1'b0;
      segLvl <= 1'b0;
      segLen <= 16'h0;
    end
    else
    begin
      segEvt <= pulseIn != cur;
      cur <= pulseIn;
      run <= (pulseIn != cur) ? 16'h1 : run + 16'h1;
      if (pulseIn != cur) segLvl <= cur;
      if (pulseIn != cur) segLen <= run;
    end
endmodule : plc_input_model
`default_nettype wire

// ===== maint_current_monitor_bench.sv
// bench for the maintenance timer and pulse monitor
`timescale 1ns/100ps
`default_nettype none
module maint_current_monitor_bench;
  import maint_monitor_pkg::*;
  logic        sys_clk, resetn, psel, penable, pwrite, pready, pslverr;
  logic        run, acc, alarm, due, pulse, evt, lvl, strobe, se;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [9:0]  cur;
  logic [2:0]  term;
  logic [13:0] hours;
  logic [15:0] len;
  int          err_count, cmp_count;
  maint_current_monitor #(.TICK_CYCLES(100), .TENTHS_HOUR(3)) dut (
    .sys_clk(sys_clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .driveRunning(run),
    .accelDecel(acc), .restartActive(1'b0), .restartSelected(1'b0),
    .outputCurrent(cur), .maintenanceAlarmOut(alarm),
    .maintenanceDueIndication(due), .currentAvgPulseOut(pulse),
    .terminalOut(term), .nvSaveStrobe(strobe), .nvSaveCount(hours));
  plc_input_model plc (.sys_clk(sys_clk), .resetn(resetn),
    .pulseIn(pulse), .segEvt(evt), .segLvl(lvl), .segLen(len));
  task automatic chk(input string n, input logic [31:0] e, g);
    cmp_count++;
    if (g !== e)
    begin
      err_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= 32'(d);
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask : apb
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 8'h0);
    chk("prdata", e, rd);
  endtask : rdc
  task automatic seg(input logic l, input int n);
    do @(posedge sys_clk); while (evt !== 1'b1);
    chk("level", 32'(l), 32'(lvl));
    if (n > 0) chk("length", n, 32'(len));
  endtask : seg
  task automatic t_regs;
    rdc(OFF_THRESH, 32'h270f);
    rdc(OFF_WINDOW, 32'ha);
    rdc(OFF_MASK, 32'h0);
    rdc(OFF_REF, 32'h5);
    apb(1'b1, OFF_HOURS, 8'h5);
    rdc(OFF_HOURS, 32'h0);
    apb(1'b1, OFF_PROTECT, 8'h1);
    apb(1'b1, OFF_REF, 8'h7);
    apb(1'b1, OFF_THRESH, 8'h3);
    rdc(OFF_REF, 32'h7);
    rdc(OFF_THRESH, 32'h270f);
    apb(1'b1, OFF_PROTECT, 8'h0);
    apb(1'b1, OFF_REF, 8'h5);
    apb(1'b0, 8'h40, 8'h0);
    chk("pslverr", 32'h1, 32'(se));
    $display("registers done");
  endtask : t_regs
  task automatic t_alarm;
    apb(1'b1, OFF_TERM_A, FUNC_ALARM_POS);
    apb(1'b1, OFF_TERM_B, FUNC_ALARM_NEG);
    apb(1'b1, OFF_RELAY, FUNC_PULSE_POS);
    rdc(OFF_RELAY, 32'h0);
    apb(1'b1, OFF_THRESH, 8'h0);
    repeat (3) @(posedge sys_clk);
    chk("alarm", 32'h1, 32'(alarm));
    chk("due", 32'h1, 32'(due));
    chk("terminal", 32'h1, 32'(term));
    apb(1'b1, OFF_THRESH, 8'hff);
    rdc(OFF_THRESH, 32'hff);
    repeat (3) @(posedge sys_clk);
    chk("terminal", 32'h2, 32'(term));
    $display("alarm done");
  endtask : t_alarm
  task automatic t_hours;
    while (hours !== 14'h1) @(posedge sys_clk);
    rdc(OFF_HOURS, 32'h1);
    apb(1'b1, OFF_HOURS, 8'h0);
    rdc(OFF_HOURS, 32'h0);
    $display("hours done");
  endtask : t_hours
  task automatic t_pulse;
    apb(1'b1, OFF_TERM_A, FUNC_PULSE_POS);
    apb(1'b1, OFF_TERM_B, FUNC_PULSE_NEG);
    run <= 1'b1;
    seg(1'b0, 0);
    seg(1'b1, 0);
    seg(1'b0, 5000);
    repeat (5) @(posedge sys_clk);
    chk("terminal", 32'h1, 32'(term));
    seg(1'b1, 2000);
    cur <= 10'h14;
    seg(1'b0, 12000);
    seg(1'b1, 1000);
    seg(1'b0, 9000);
    seg(1'b1, 2000);
    seg(1'b0, 8000);
    acc <= 1'b1;
    seg(1'b1, 3500);
    $display("pulse done");
  endtask : t_pulse
  task automatic complete_run;
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : complete_run
  initial
  begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  initial
  begin
    {resetn, psel, penable, pwrite, run, acc} = 6'h0;
    {paddr, pwdata, cur} = {8'h0, 32'h0, 10'h5};
    repeat (6) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    t_regs;
    t_alarm;
    t_hours;
    t_pulse;
    complete_run;
  end
  initial
  begin
    repeat (90000) @(posedge sys_clk);
    err_count++;
    complete_run;
  end
endmodule : maint_current_monitor_bench
bind maint_current_monitor maint_current_monitor_props #(
  .TICK_CYCLES(TICK_CYCLES), .TENTHS_HOUR(TENTHS_HOUR)) props (
  .sys_clk(sys_clk), .resetn(resetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .paddr(paddr), .pwdata(pwdata),
  .maintenanceAlarmOut(maintenanceAlarmOut),
  .maintenanceDueIndication(maintenanceDueIndication),
  .nvSaveStrobe(nvSaveStrobe), .nvSaveCount(nvSaveCount));
`default_nettype wire
